// file: rtl/dhs_pkg.sv
// package of constants and types for the dog type homing sequencer
// =====================================================================
// Summary of operation
// - home is the first encoder zero point seen after the dog goes from on to off.
// - with no zero pass before the dog-off stop, the axis stops, minor error 120 is raised and homing does not complete.
// - with the z-phase waiver option set, homing completes even without a zero pass before the dog-off stop.
// - if the dog goes off before creep speed is reached, the axis drops straight to creep speed and the next zero point becomes home.
// - a start while the dog is already on is refused with major error 1003.
// - with retry disabled, a new start after a completed return is refused with minor error 115.
// - the return is not finished until the in-position indication is on.
package dhs_pkg;

    // =================================================================
    // register map
    localparam logic [3:0] DHS_ADDR_CTRL = 4'h0;
    localparam logic [3:0] DHS_ADDR_STATUS = 4'h1;
    localparam logic [3:0] DHS_ADDR_ERROR = 4'h2;
    localparam logic [3:0] DHS_ADDR_DECEL = 4'h3;

    // ctrl bit positions
    localparam int DHS_CTRL_START = 0;
    localparam int DHS_CTRL_RETRY = 1;
    localparam int DHS_CTRL_WAIVER = 2;
    localparam int DHS_CTRL_ABORT = 3;

    localparam logic [31:0] DHS_CTRL_RESET = 32'h0000_0000;
    localparam logic [15:0] DHS_DECEL_RESET = 16'h0100;

    // =================================================================
    // error codes
    localparam logic [15:0] DHS_ERR_NONE = 16'h0000;
    localparam logic [15:0] DHS_ERR_NO_ZERO = 16'h0078;
    localparam logic [15:0] DHS_ERR_REPEAT = 16'h0073;
    localparam logic [15:0] DHS_ERR_DOG_ON = 16'h03EB;

    // =================================================================
    // speed command to the drive
    typedef enum logic [1:0] {
        DHS_SPD_STOP = 2'h0,
        DHS_SPD_RETURN = 2'h1,
        DHS_SPD_CREEP = 2'h2
    } dhs_speed_t;

    typedef struct packed {
        logic dog;
        logic zero_pass;
        logic zero_point;
        logic in_position;
    } dhs_servo_in_t;

    typedef struct packed {
        logic busy;
        logic done;
        logic minor_err;
        logic major_err;
    } dhs_status_t;

endpackage : dhs_pkg

// file: rtl/dhs_sync.sv
// two-flop synchroniser with rise and fall events
`timescale 1ns/1ps
`default_nettype none
module dhs_sync #(
    parameter int WIDTH = 4
) (
    input wire logic sys_clk,              // system clock
    input wire logic rstn,                 // async reset, active low
    input wire logic [WIDTH-1:0] async_in, // raw pins
    output logic [WIDTH-1:0] level,        // synchronised level
    output logic [WIDTH-1:0] rise,         // one-cycle rise event
    output logic [WIDTH-1:0] fall          // one-cycle fall event
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] prev;

    // =================================================================
    // meta is read only by level
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta <= '0;
            level <= '0;
            prev <= '0;
        end
        else
        begin
            meta <= async_in;
            level <= meta;
            prev <= level;
        end
    end

    assign rise = level & ~prev;
    assign fall = ~level & prev;
endmodule : dhs_sync
`default_nettype wire

// file: rtl/dhs_top.sv
// dog type homing sequencer with avalon-mm register slave
//
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dhs_top (
    input wire logic sys_clk,                  // 125 MHz clock
    input wire logic rstn,                     // async reset, active low
    input wire logic [3:0] avs_address,        // word address
    input wire logic avs_read,                 // read strobe
    input wire logic avs_write,                // write strobe
    input wire logic [31:0] avs_writedata,     // write data
    input wire logic [3:0] avs_byteenable,     // byte lanes
    output logic [31:0] avs_readdata,          // read data
    output logic avs_waitrequest,              // stall
    input wire dhs_pkg::dhs_servo_in_t servo_in, // raw servo pins
    input wire logic decel_reached,            // drive at creep speed
    output dhs_pkg::dhs_speed_t speed_cmd,     // speed command
    output logic home_latch,                   // one-cycle home capture
    output dhs_pkg::dhs_status_t status        // status flags
);
    import dhs_pkg::*;

    typedef enum logic [6:0] {
        S_IDLE = 7'b0000001,
        S_FAST = 7'b0000010,
        S_CREEP = 7'b0000100,
        S_STOP_ERR = 7'b0001000,
        S_SEEK_Z = 7'b0010000,
        S_INPOS = 7'b0100000,
        S_DONE = 7'b1000000
    } dhs_state_t;

    dhs_state_t state;
    dhs_state_t next_state;

    // =================================================================
    // input synchronisation
    logic [3:0] sync_lvl;
    logic [3:0] sync_rise;
    logic [3:0] sync_fall;

    dhs_sync #(
        .WIDTH(4)
    ) u_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .async_in(servo_in),
        .level(sync_lvl),
        .rise(sync_rise),
        .fall(sync_fall)
    );

    wire dog_lvl = sync_lvl[3];
    wire dog_fall = sync_fall[3];
    wire zero_pass_flag = sync_lvl[2];
    wire zero_edge = sync_rise[1];
    wire in_position_flag = sync_lvl[0];

    // =================================================================
    // register bus
    logic retry_en;
    logic z_phase_waiver_option;
    logic [15:0] decel_timeout;
    logic [15:0] err_code;
    logic start_pend;
    logic abort_pend;
    logic ack;
    logic homed;
    logic zero_seen;
    logic [15:0] decel_cnt;
    logic minor_err;
    logic major_err;

    wire bus_req = (avs_read | avs_write) & ~ack;
    // a write lands only on the edge where waitrequest is low
    wire wr_hit = avs_write & ack;
    wire rd_hit = avs_read & ~ack;
    wire wr_ctrl = wr_hit & (avs_address == DHS_ADDR_CTRL) & avs_byteenable[0];
    wire wr_decel = wr_hit & (avs_address == DHS_ADDR_DECEL);
    wire rd_err = rd_hit & (avs_address == DHS_ADDR_ERROR);

    function automatic logic [31:0] rd_mux(input logic [3:0] a,
                                           input logic [31:0] ctl,
                                           input logic [31:0] st,
                                           input logic [31:0] er,
                                           input logic [31:0] dc);
        case (a)
            DHS_ADDR_CTRL: rd_mux = ctl;
            DHS_ADDR_STATUS: rd_mux = st;
            DHS_ADDR_ERROR: rd_mux = er;
            DHS_ADDR_DECEL: rd_mux = dc;
            default: rd_mux = 32'h0000_0000;
        endcase
    endfunction : rd_mux

    wire [31:0] ctrl_word = {28'h0000000, 1'b0, z_phase_waiver_option,
                             retry_en, 1'b0};
    wire [31:0] status_word = {25'h0000000, state};
    wire [31:0] err_word = {16'h0000, err_code};
    wire [31:0] decel_word = {16'h0000, decel_timeout};
    wire [31:0] next_readdata = rd_mux(avs_address, ctrl_word, status_word,
                                       err_word, decel_word);

    // one wait cycle per access; unmapped reads give zero, writes drop
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            ack <= bus_req;
            avs_waitrequest <= ~bus_req;
            avs_readdata <= bus_req ? next_readdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            retry_en <= DHS_CTRL_RESET[DHS_CTRL_RETRY];
            z_phase_waiver_option <= DHS_CTRL_RESET[DHS_CTRL_WAIVER];
            decel_timeout <= DHS_DECEL_RESET;
        end
        else
        begin
            if (wr_ctrl)
            begin
                retry_en <= avs_writedata[DHS_CTRL_RETRY];
                z_phase_waiver_option <= avs_writedata[DHS_CTRL_WAIVER];
            end
            if (wr_decel)
                decel_timeout <= avs_writedata[15:0];
        end
    end

    wire start_wr = wr_ctrl & avs_writedata[DHS_CTRL_START];
    wire abort_wr = wr_ctrl & avs_writedata[DHS_CTRL_ABORT];

    // =================================================================
    // sequencer
    wire refuse_dog = dog_lvl;
    wire refuse_rep = homed & ~retry_en;
    wire go = start_pend & ~refuse_dog & ~refuse_rep;
    wire zero_ok = zero_seen | zero_pass_flag | z_phase_waiver_option;
    wire creep_hit = decel_reached | (decel_cnt == 16'h0000);

    always_comb
    begin
        next_state = state;
        unique case (state)
            S_IDLE:
            begin
                if (go)
                    next_state = S_FAST;
            end
            S_FAST:
            begin
                if (abort_pend)
                    next_state = S_IDLE;
                else if (dog_fall)
                    next_state = zero_ok ? S_SEEK_Z : S_STOP_ERR;
                else if (dog_lvl & creep_hit)
                    next_state = S_CREEP;
            end
            S_CREEP:
            begin
                if (abort_pend)
                    next_state = S_IDLE;
                else if (dog_fall)
                    next_state = zero_ok ? S_SEEK_Z : S_STOP_ERR;
            end
            S_STOP_ERR:
                next_state = S_IDLE;
            S_SEEK_Z:
            begin
                if (abort_pend)
                    next_state = S_IDLE;
                else if (zero_edge)
                    next_state = S_INPOS;
            end
            S_INPOS:
            begin
                if (in_position_flag)
                    next_state = S_DONE;
            end
            S_DONE:
                next_state = S_IDLE;
            default:
                next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            state <= S_IDLE;
        else
            state <= next_state;
    end

    // start is held until the sequencer is idle to take it; abort lasts one cycle
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            start_pend <= 1'b0;
            abort_pend <= 1'b0;
        end
        else
        begin
            start_pend <= start_wr | (start_pend & (state != S_IDLE));
            abort_pend <= abort_wr;
        end
    end

    // zero pass is remembered from start; the dog-on timer guards creep
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            zero_seen <= 1'b0;
            decel_cnt <= 16'h0000;
        end
        else if (state == S_IDLE)
        begin
            zero_seen <= 1'b0;
            decel_cnt <= decel_timeout;
        end
        else
        begin
            zero_seen <= zero_seen | zero_edge;
            if (state == S_FAST && dog_lvl && decel_cnt != 16'h0000)
                decel_cnt <= decel_cnt - 16'h0001;
        end
    end

    // errors are sticky; a new event wins over a read clear
    wire set_120 = (next_state == S_STOP_ERR) & (state != S_STOP_ERR);
    wire set_1003 = start_pend & (state == S_IDLE) & refuse_dog;
    wire set_115 = start_pend & (state == S_IDLE) & ~refuse_dog & refuse_rep;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            err_code <= DHS_ERR_NONE;
            minor_err <= 1'b0;
            major_err <= 1'b0;
        end
        else if (set_1003)
        begin
            err_code <= DHS_ERR_DOG_ON;
            major_err <= 1'b1;
        end
        else if (set_115)
        begin
            err_code <= DHS_ERR_REPEAT;
            minor_err <= 1'b1;
        end
        else if (set_120)
        begin
            err_code <= DHS_ERR_NO_ZERO;
            minor_err <= 1'b1;
        end
        else if (rd_err)
        begin
            err_code <= DHS_ERR_NONE;
            minor_err <= 1'b0;
            major_err <= 1'b0;
        end
    end

    // =================================================================
    // outputs
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            speed_cmd <= DHS_SPD_STOP;
            home_latch <= 1'b0;
            homed <= 1'b0;
            status <= '0;
        end
        else
        begin
            unique case (next_state)
                S_FAST: speed_cmd <= DHS_SPD_RETURN;
                S_CREEP: speed_cmd <= DHS_SPD_CREEP;
                // after an early dog-off the axis goes straight to creep to z
                S_SEEK_Z: speed_cmd <= DHS_SPD_CREEP;
                default: speed_cmd <= DHS_SPD_STOP;
            endcase
            home_latch <= (state == S_SEEK_Z) & zero_edge;
            if (state == S_DONE)
                homed <= 1'b1;
            status.busy <= (next_state != S_IDLE) & (next_state != S_DONE);
            status.done <= (next_state == S_DONE) | (status.done & ~go);
            status.minor_err <= minor_err;
            status.major_err <= major_err;
        end
    end
endmodule : dhs_top
`default_nettype wire

// file: verification/dhs_sva.sv
// port assertions for the homing sequencer
`timescale 1ns/1ps
`default_nettype none
module dhs_sva (
    input wire logic sys_clk, // clock
    input wire logic rstn, // reset, active low
    input wire dhs_pkg::dhs_servo_in_t servo_in, // servo pins
    input wire dhs_pkg::dhs_speed_t speed_cmd, // speed command
    input wire logic home_latch, // home pulse
    input wire dhs_pkg::dhs_status_t status // flags
);
    import dhs_pkg::*;
    // =========================================================
    // age of the last raw zero point, saturating
    logic [3:0] zp_age;
    always_ff @(posedge sys_clk or negedge rstn)
        if (!rstn)
            zp_age <= 4'hF;
        else if (servo_in.zero_point)
            zp_age <= 4'h0;
        else if (zp_age != 4'hF)
            zp_age <= zp_age + 4'h1;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // =========================================================
    // properties
    property p_home_dog_off;
        home_latch |-> !servo_in.dog;
    endproperty
    property p_home_pulse;
        home_latch |=> !home_latch;
    endproperty
    property p_home_zero;
        home_latch |-> zp_age <= 4'h6;
    endproperty
    property p_home_stop;
        home_latch |=> speed_cmd == DHS_SPD_STOP;
    endproperty
    property p_done_inpos;
        $rose(status.done) |-> servo_in.in_position
            && speed_cmd == DHS_SPD_STOP;
    endproperty
    property p_major_dog;
        $rose(status.major_err) |-> servo_in.dog;
    endproperty
    property p_major_stop;
        $rose(status.major_err) |-> speed_cmd == DHS_SPD_STOP [*4];
    endproperty
    property p_minor_stop;
        $rose(status.minor_err) |-> ##[0:2] speed_cmd == DHS_SPD_STOP;
    endproperty
    a_home_dog_off: assert property (p_home_dog_off)
        else $error("home taken while dog on");
    a_home_pulse: assert property (p_home_pulse)
        else $error("home pulse longer than one cycle");
    a_home_zero: assert property (p_home_zero)
        else $error("home taken without a zero point");
    a_home_stop: assert property (p_home_stop)
        else $error("axis still moving after home");
    a_done_inpos: assert property (p_done_inpos)
        else $error("done without in-position");
    a_major_dog: assert property (p_major_dog)
        else $error("major error without dog on");
    a_major_stop: assert property (p_major_stop)
        else $error("refused return moved the axis");
    a_minor_stop: assert property (p_minor_stop)
        else $error("axis not stopped on minor error");
    c_home: cover property (home_latch);
    c_major: cover property ($rose(status.major_err));
    c_done: cover property ($rose(status.done));
endmodule : dhs_sva
bind dhs_top dhs_sva u_sva (.sys_clk(sys_clk), .rstn(rstn),
    .servo_in(servo_in), .speed_cmd(speed_cmd),
    .home_latch(home_latch), .status(status));
`default_nettype wire

// file: verification/dhs_servo_model.sv
// servo amplifier, encoder and dog model
`timescale 1ns/1ps
`default_nettype none
module dhs_servo_model (
    input wire logic sys_clk, // clock
    input wire logic rstn, // reset, active low
    input wire dhs_pkg::dhs_speed_t speed_cmd, // speed command
    input wire logic ld, // move axis back to zero
    input wire logic [11:0] dog_start, // dog on point
    input wire logic [11:0] dog_len, // dog length
    input wire logic zp_en, // encoder zero already passed
    input wire logic inpos_hold, // keep in-position off
    output dhs_pkg::dhs_servo_in_t servo_in, // servo pins
    output logic decel_reached, // creep speed reached
    output logic [11:0] pos, // axis position
    output logic [11:0] last_zp // position of last zero point
);
    import dhs_pkg::*;
    // 16 steps per revolution; creep is a quarter of return speed
    logic [1:0] div;
    logic [4:0] dog_cnt;
    logic [3:0] still;
    logic zp_r;
    wire moving = speed_cmd != DHS_SPD_STOP;
    wire step = speed_cmd == DHS_SPD_RETURN
        || (speed_cmd == DHS_SPD_CREEP && div == 2'h3);
    wire [11:0] next_pos = pos + 12'h1;
    wire [11:0] dog_end = dog_start + dog_len;
    wire dog = pos >= dog_start && pos < dog_end;
    // no zero pulses before the dog end unless the encoder has passed one
    wire zp_now = step && next_pos[3:0] == 4'h0
        && (zp_en || next_pos >= dog_end);
    always_ff @(posedge sys_clk or negedge rstn)
        if (!rstn)
        begin
            pos <= 12'h0;
            div <= 2'h0;
            dog_cnt <= 5'h0;
            still <= 4'h0;
            zp_r <= 1'b0;
            last_zp <= 12'h0;
        end
        else
        begin
            div <= div + 2'h1;
            pos <= ld ? 12'h0 : (step ? next_pos : pos);
            zp_r <= zp_now;
            if (zp_now)
                last_zp <= next_pos;
            dog_cnt <= (dog && moving) ?
                dog_cnt + {4'h0, dog_cnt != 5'h1F} : 5'h0;
            still <= moving ? 4'h0 : still + {3'h0, still != 4'hF};
        end
    assign decel_reached = dog_cnt >= 5'h14;
    assign servo_in = '{dog: dog, zero_pass: zp_en, zero_point: zp_r,
        in_position: still == 4'hF && !inpos_hold};
endmodule : dhs_servo_model
`default_nettype wire

// file: verification/tb.sv
// self-checking testbench for the homing sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dhs_pkg::*;
    int num_errors = 0;
    int checks_done = 0;
    logic sys_clk, rstn, avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd;
    dhs_servo_in_t servo_in;
    dhs_speed_t speed_cmd;
    dhs_status_t status;
    logic decel_reached, home_latch, ld, zp_en, inpos_hold;
    logic [11:0] dog_start, dog_len, pos, last_zp, ds;
    dhs_top u_dut (.sys_clk(sys_clk), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .servo_in(servo_in),
        .decel_reached(decel_reached), .speed_cmd(speed_cmd),
        .home_latch(home_latch), .status(status));
    dhs_servo_model u_srv (.sys_clk(sys_clk), .rstn(rstn),
        .speed_cmd(speed_cmd), .ld(ld), .dog_start(dog_start),
        .dog_len(dog_len), .zp_en(zp_en), .inpos_hold(inpos_hold),
        .servo_in(servo_in), .decel_reached(decel_reached),
        .pos(pos), .last_zp(last_zp));
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // =========================================================
    // tasks
    task automatic conclude;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do
            @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    function automatic logic [11:0] exp_home(input logic [11:0] e);
        return (e | 12'h00F) + 12'h1;
    endfunction : exp_home
    // the axis is always moved back to position zero first
    task automatic place(input logic [11:0] s, len, input logic z);
        // let an edge pass so no pin is driven twice in one step
        @(posedge sys_clk);
        ld <= 1'b1;
        dog_start <= s;
        dog_len <= len;
        zp_en <= z;
        inpos_hold <= 1'b1;
        @(posedge sys_clk);
        ld <= 1'b0;
        repeat (8) @(posedge sys_clk);
    endtask : place
    task automatic run(input logic [11:0] len, input logic z, wv, ok);
        // dog end half a revolution before a zero point
        ds = 12'h10 * (12'h5 + 12'($urandom % 8)) + 12'h8 - len;
        place(ds, len, z);
        bus(1'b1, DHS_ADDR_CTRL, {29'h0, wv, 2'h3});
        if (ok)
        begin
            while (home_latch !== 1'b1) @(posedge sys_clk);
            chk("home", {20'h0, exp_home(ds + len)},
                {20'h0, last_zp});
            repeat (40) @(posedge sys_clk);
            chk("done early", 32'h0, {31'h0, status.done});
            inpos_hold <= 1'b0;
            while (status.done !== 1'b1) @(posedge sys_clk);
            bus(1'b0, DHS_ADDR_ERROR, 32'h0);
            chk("error", 32'h0, rd);
        end
        else
        begin
            while (status.minor_err !== 1'b1) @(posedge sys_clk);
            bus(1'b0, DHS_ADDR_ERROR, 32'h0);
            chk("error", {16'h0, DHS_ERR_NO_ZERO}, rd);
            chk("done", 32'h0, {31'h0, status.done});
            inpos_hold <= 1'b0;
        end
    endtask : run
    // =========================================================
    // main sequence: register reads, homing runs, then abort
    initial
    begin
        void'($urandom(32'hA49C));
        rstn = 1'b0;
        {avs_read, avs_write, ld, inpos_hold} = 4'h0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        {dog_start, dog_len, zp_en} = {12'h0, 12'h40, 1'b1};
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        bus(1'b0, DHS_ADDR_STATUS, 32'h0);
        chk("status", 32'h1, rd);
        bus(1'b0, DHS_ADDR_DECEL, 32'h0);
        chk("decel", {16'h0, DHS_DECEL_RESET}, rd);
        bus(1'b0, 4'h9, 32'h0);
        chk("unmapped", 32'h0, rd);
        place(12'h0, 12'h40, 1'b1);
        bus(1'b1, DHS_ADDR_CTRL, 32'h1);
        while (status.major_err !== 1'b1) @(posedge sys_clk);
        bus(1'b0, DHS_ADDR_ERROR, 32'h0);
        chk("error", {16'h0, DHS_ERR_DOG_ON}, rd);
        chk("busy", 32'h0, {31'h0, status.busy});
        inpos_hold <= 1'b0;
        run(12'h40, 1'b1, 1'b0, 1'b1);
        bus(1'b1, DHS_ADDR_CTRL, 32'h1);
        while (status.minor_err !== 1'b1) @(posedge sys_clk);
        bus(1'b0, DHS_ADDR_ERROR, 32'h0);
        chk("error", {16'h0, DHS_ERR_REPEAT}, rd);
        chk("speed", {30'h0, DHS_SPD_STOP}, {30'h0, speed_cmd});
        repeat (2)
        begin
            run(12'h40, 1'b0, 1'b0, 1'b0);
            run(12'h40, 1'b0, 1'b1, 1'b1);
            run(12'h4, 1'b1, 1'b0, 1'b1);
        end
        // a short dog-on timeout must bring creep well before the drive flag
        bus(1'b1, DHS_ADDR_DECEL, 32'h4);
        bus(1'b0, DHS_ADDR_DECEL, 32'h0);
        chk("decel", 32'h4, rd);
        place(12'h40, 12'h40, 1'b1);
        bus(1'b1, DHS_ADDR_CTRL, 32'h3);
        while (speed_cmd !== DHS_SPD_CREEP) @(posedge sys_clk);
        chk("creep early", 32'h1, {31'h0, pos < 12'h50});
        bus(1'b1, DHS_ADDR_CTRL, 32'hA);
        repeat (4) @(posedge sys_clk);
        chk("abort busy", 32'h0, {31'h0, status.busy});
        chk("abort speed", {30'h0, DHS_SPD_STOP}, {30'h0, speed_cmd});
        conclude();
    end
    initial
    begin
        repeat (50000) @(posedge sys_clk);
        num_errors++;
        conclude();
    end
endmodule : tb
`default_nettype wire
